// *** rtl/surface_origin_offset_decode.sv ***
// ahb-lite register front end of the surface origin decoder
`timescale 1ns/1ps
`default_nettype none
`include "surface_origin_regs.svh"
module surface_origin_offset_decode (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      originAddr,
   output logic [9:0]       viewExtent
);
   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      surface_origin_pkg::ahb_req_t req;
      logic [31:0] base;
      logic [31:0] descExtent;
      logic [31:0] descOffset;
      logic [31:0] pitch;
      logic        media;
      logic [2:0]  bpp;
      logic [31:0] rdata;
      logic [31:0] origin;
      logic [9:0]  extent;
   } state_t;
   state_t state_reg;
   state_t state_next;
   surface_origin_pkg::decode_t dec;

   // ****************************************************************
   // arithmetic
   // ****************************************************************
   origin_calc u_calc (
      .clk         (clk),
      .reset       (reset),
      .baseAddr    (state_reg.base),
      .descExtent  (state_reg.descExtent),
      .descOffset  (state_reg.descOffset),
      .pitchBytes  (state_reg.pitch),
      .mediaAccess (state_reg.media),
      .bppLog2     (state_reg.bpp),
      .result      (dec)
   );

   // read decode used for both rdata and nothing else; kept as a function for clarity
   function automatic logic [31:0] readMux(input state_t s, input surface_origin_pkg::decode_t d,
                                           input logic [11:0] a);
      unique case (a)
         `ADDR_BASE:        readMux = s.base;
         `ADDR_DESC_EXTENT: readMux = s.descExtent;
         `ADDR_DESC_OFFSET: readMux = s.descOffset;
         `ADDR_PITCH:       readMux = s.pitch;
         `ADDR_CTRL:        readMux = {25'h0, s.bpp, 3'h0, s.media};
         `ADDR_ORIGIN:      readMux = d.origin;
         `ADDR_EXTENT:      readMux = {22'h0, d.extent};
         `ADDR_XPIX:        readMux = {23'h0, d.xPixels};
         `ADDR_YROW:        readMux = {27'h0, d.yRows};
         default:           readMux = 32'h0000_0000;
      endcase
   endfunction

   // ****************************************************************
   // bus slave: zero wait states, unmapped reads zero, writes to read-only and unmapped places ignored
   // ****************************************************************
   always_comb begin
      state_next = state_reg;
      if (state_reg.req.valid && state_reg.req.write) begin
         unique case (state_reg.req.addr)
            `ADDR_BASE:        state_next.base = hwdata;
            `ADDR_DESC_EXTENT: state_next.descExtent = hwdata;
            `ADDR_DESC_OFFSET: state_next.descOffset = hwdata;
            `ADDR_PITCH:       state_next.pitch = hwdata;
            `ADDR_CTRL: begin
               state_next.media = hwdata[`CTRL_MEDIA_BIT];
               state_next.bpp   = hwdata[`CTRL_BPP_LSB +: 3];
            end
            default: ;
         endcase
      end
      state_next.req.valid = hsel && hready && htrans[1];
      state_next.req.write = hwrite;
      state_next.req.addr  = {haddr[11:2], 2'b00};
      // read data registered at the address phase: one cycle after acceptance
      state_next.rdata  = readMux(state_reg, dec, {haddr[11:2], 2'b00});
      state_next.origin = dec.origin;
      state_next.extent = dec.extent;
   end

   // register file, read data and outputs; outputs trail the calc stage by one edge
   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg      <= '0;
         state_reg.bpp  <= `RESET_BPP;
         hrdata         <= 32'h0000_0000;
         hreadyout      <= 1'b1;
         hresp          <= 1'b0;
         originAddr     <= 32'h0000_0000;
         viewExtent     <= 10'h000;
      end else begin
         state_reg  <= state_next;
         hrdata     <= state_next.rdata;
         hreadyout  <= 1'b1;
         hresp      <= 1'b0;
         originAddr <= dec.origin;
         viewExtent <= dec.extent;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   // the calc stage trails the registers by one edge; the edge right after reset is skipped
   property p_extent;
      @(posedge clk) disable iff (reset)
      !$past(reset) |-> dec.extent == {1'b0, $past(state_reg.descExtent[`EXTENT_LSB +: 9])} + 10'h001;
   endproperty
   a_extent: assert property (p_extent) else $error("extent not field plus one");

   // horizontal field lands in pixel bits 8:2
   property p_xoff;
      @(posedge clk) disable iff (reset)
      !$past(reset) |-> dec.xPixels == {$past(state_reg.descOffset[`XOFF_MSB:`XOFF_LSB]), 2'b00};
   endproperty
   a_xoff: assert property (p_xoff) else $error("x offset decode wrong");

   // vertical field lands in row bits 4:1
   property p_yoff;
      @(posedge clk) disable iff (reset)
      !$past(reset) |-> dec.yRows == {$past(state_reg.descOffset[`YOFF_MSB:`YOFF_LSB]), 1'b0};
   endproperty
   a_yoff: assert property (p_yoff) else $error("y offset decode wrong");

   // with no row offset the origin moves only in whole groups of four pixels
   property p_grid;
      @(posedge clk) disable iff (reset)
      (!$past(reset) && $past(state_reg.descOffset[`YOFF_MSB:`YOFF_LSB]) == 4'h0) |->
         ((dec.origin - {$past(state_reg.base[31:`BASE_ALIGN_BITS]), 12'h000})
            & ((32'h0000_0004 << ($past(state_reg.media) ? `MEDIA_BPP_LOG2 : $past(state_reg.bpp)))
               - 32'h0000_0001)) == 32'h0000_0000;
   endproperty
   a_grid: assert property (p_grid) else $error("origin off 4x2 grid");

   // media access scales the pixel offset by four bytes whatever the format says
   property p_media;
      @(posedge clk) disable iff (reset)
      (!$past(reset) && $past(state_reg.media) && $past(state_reg.descOffset[`YOFF_MSB:`YOFF_LSB]) == 4'h0) |->
         dec.origin == {$past(state_reg.base[31:`BASE_ALIGN_BITS]), 12'h000}
                       + {21'h0, $past(state_reg.descOffset[`XOFF_MSB:`XOFF_LSB]), 4'h0};
   endproperty
   a_media: assert property (p_media) else $error("media path not 32-bit pixels");

   // with both offsets zero the origin is the aligned base itself
   property p_base;
      @(posedge clk) disable iff (reset)
      (!$past(reset) && $past(state_reg.descOffset[31:20]) == 12'h000) |->
         dec.origin == {$past(state_reg.base[31:`BASE_ALIGN_BITS]), 12'h000};
   endproperty
   a_base: assert property (p_base) else $error("zero offset origin not aligned base");

   // appended zero bits keep the origin word aligned when no row offset applies
   property p_zeros;
      @(posedge clk) disable iff (reset)
      (!$past(reset) && $past(state_reg.descOffset[`YOFF_MSB:`YOFF_LSB]) == 4'h0) |-> dec.origin[1:0] == 2'b00;
   endproperty
   a_zeros: assert property (p_zeros) else $error("appended zero bits not zero");

   // with no pixel offset the origin moves by whole rows of the pitch
   property p_rows;
      @(posedge clk) disable iff (reset)
      (!$past(reset) && $past(state_reg.descOffset[`XOFF_MSB:`XOFF_LSB]) == 7'h00) |->
         dec.origin == {$past(state_reg.base[31:`BASE_ALIGN_BITS]), 12'h000}
                       + 32'({27'h0, $past(state_reg.descOffset[`YOFF_MSB:`YOFF_LSB]), 1'b0} * $past(state_reg.pitch));
   endproperty
   a_rows: assert property (p_rows) else $error("row offset not whole rows of pitch");

   // top outputs are the calc result one edge later
   property p_out;
      @(posedge clk) disable iff (reset)
      !$past(reset) |-> originAddr == $past(dec.origin) && viewExtent == $past(dec.extent);
   endproperty
   a_out: assert property (p_out) else $error("outputs do not follow decode");

   // a write in its data phase reaches the offset word at the next edge
   property p_write;
      @(posedge clk) disable iff (reset)
      (!$past(reset) && $past(state_reg.req.valid) && $past(state_reg.req.write)
         && $past(state_reg.req.addr) == `ADDR_DESC_OFFSET) |-> state_reg.descOffset == $past(hwdata);
   endproperty
   a_write: assert property (p_write) else $error("offset write did not land");

   // a control write sets the media bit and the pixel size together
   property p_ctrl;
      @(posedge clk) disable iff (reset)
      (!$past(reset) && $past(state_reg.req.valid) && $past(state_reg.req.write)
         && $past(state_reg.req.addr) == `ADDR_CTRL)
         |-> state_reg.media == $past(hwdata[`CTRL_MEDIA_BIT])
             && state_reg.bpp == $past(hwdata[`CTRL_BPP_LSB +: 3]);
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("control write did not land");

   // the base word changes only through its own write
   property p_ro;
      @(posedge clk) disable iff (reset)
      (!$past(reset) && !($past(state_reg.req.valid) && $past(state_reg.req.write)
         && $past(state_reg.req.addr) == `ADDR_BASE)) |-> state_reg.base == $past(state_reg.base);
   endproperty
   a_ro: assert property (p_ro) else $error("base changed without its write");

   // zero wait states and an okay response on every cycle
   property p_ready;
      @(posedge clk) disable iff (reset)
      hreadyout && !hresp;
   endproperty
   a_ready: assert property (p_ready) else $error("slave stalled or errored");
endmodule
`default_nettype wire

// *** rtl/surface_origin_regs.svh ***
// register offsets, field positions and reset values of the surface origin decoder
// Functional notes
// - view extent field is depth count minus one
// - bits 31:25 give horizontal offset bits 8:2
// - origin lands on a four by two grid
// - media block access assumes 32-bit pixels
// - bits 23:20 give vertical offset bits 4:1
// - origin equals 4KB-aligned base plus offsets
`ifndef SURFACE_ORIGIN_REGS_SVH
`define SURFACE_ORIGIN_REGS_SVH
// byte addresses of the word registers
`define ADDR_BASE        12'h000
`define ADDR_DESC_EXTENT 12'h004
`define ADDR_DESC_OFFSET 12'h008
`define ADDR_PITCH       12'h00c
`define ADDR_CTRL        12'h010
`define ADDR_ORIGIN      12'h014
`define ADDR_EXTENT      12'h018
`define ADDR_XPIX        12'h01c
`define ADDR_YROW        12'h020
// field positions
`define EXTENT_MSB       29
`define EXTENT_LSB       21
`define XOFF_MSB         31
`define XOFF_LSB         25
`define YOFF_MSB         23
`define YOFF_LSB         20
`define CTRL_MEDIA_BIT   0
`define CTRL_BPP_LSB     4
// base alignment: low 12 bits are dropped (4KB)
`define BASE_ALIGN_BITS  12
// reset values
`define RESET_WORD       32'h0000_0000
`define RESET_BPP        3'h2
// media block messages always treat pixels as 4 bytes
`define MEDIA_BPP_LOG2   3'h2
`endif

// *** rtl/surface_origin_pkg.sv ***
// types shared by the surface origin decoder
package surface_origin_pkg;
   // ahb request captured in the address phase
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [11:0] addr;
   } ahb_req_t;
   // decoded origin placement
   typedef struct packed {
      logic [9:0]  extent;
      logic [8:0]  xPixels;
      logic [4:0]  yRows;
      logic [31:0] origin;
   } decode_t;
endpackage

// *** rtl/origin_calc.sv ***
// combinational-to-register origin arithmetic of one descriptor
`timescale 1ns/1ps
`default_nettype none
`include "surface_origin_regs.svh"
module origin_calc (
   input  wire logic                    clk,
   input  wire logic                    reset,
   input  wire logic [31:0]             baseAddr,
   input  wire logic [31:0]             descExtent,
   input  wire logic [31:0]             descOffset,
   input  wire logic [31:0]             pitchBytes,
   input  wire logic                    mediaAccess,
   input  wire logic [2:0]              bppLog2,
   output var  surface_origin_pkg::decode_t result
);
   surface_origin_pkg::decode_t result_reg;
   surface_origin_pkg::decode_t result_next;
   logic [2:0]  effBpp;
   logic [31:0] xBytes;
   logic [31:0] yBytes;
   logic [31:0] alignedBase;

   // decode offsets and form the origin address
   always_comb begin
      result_next        = result_reg;
      // extent 0..511 maps to 1..512
      result_next.extent = {1'b0, descExtent[`EXTENT_LSB +: 9]} + 10'h001;
      // two zero bits appended below the x field
      result_next.xPixels = {descOffset[`XOFF_MSB:`XOFF_LSB], 2'b00};
      // one zero bit appended below the y field
      result_next.yRows   = {descOffset[`YOFF_MSB:`YOFF_LSB], 1'b0};
      // media block path ignores format and uses 32-bit pixels
      effBpp      = mediaAccess ? `MEDIA_BPP_LOG2 : bppLog2;
      xBytes      = {23'h0, result_next.xPixels} << effBpp;
      yBytes      = 32'({27'h0, result_next.yRows} * pitchBytes);
      // base is taken 4KB aligned; origin itself need not be
      alignedBase = {baseAddr[31:`BASE_ALIGN_BITS], 12'h000};
      result_next.origin = alignedBase + xBytes + yBytes;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         result_reg <= '0;
      end else begin
         result_reg <= result_next;
      end
   end
   assign result = result_reg;
endmodule
`default_nettype wire

// *** testbench/surface_origin_offset_decode_tb.sv ***
// self-checking bench of the surface origin decoder register front end
`timescale 1ns/1ps
`default_nettype none
`include "surface_origin_regs.svh"
module surface_origin_offset_decode_tb;
   // ************
   // signals
   // ************
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic        hready;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] originAddr;
   logic [9:0]  viewExtent;
   logic [31:0] rd;
   int          err_count = 0;
   int          total_checks = 0;
   int          cycles = 0;
   // single slave: its ready is the bus ready
   assign hready = hreadyout;
   always #2 clk = ~clk;
   surface_origin_offset_decode dut_u (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .originAddr(originAddr), .viewExtent(viewExtent));
   // ************
   // helpers
   // ************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // one transfer: address phase held until ready, then data phase held until ready
   task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wr ? d : 32'h0;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      check({31'h0, hresp}, 32'h0);
   endtask
   // outputs settle two cycles after a write lands; the third edge is the first at which the bench sees them
   task automatic settle();
      repeat (3) @(posedge clk);
   endtask
   // ************
   // scenarios
   // ************
   task automatic testReset();
      settle();
      ahb(1'b0, `ADDR_CTRL, 32'h0);
      check(rd, 32'h0000_0020);
      ahb(1'b0, `ADDR_BASE, 32'h0);
      check(rd, 32'h0);
      check({22'h0, viewExtent}, 32'h1);
      check(originAddr, 32'h0);
   endtask
   // extent boundaries: field 0 and 511
   task automatic testExtent();
      logic [9:0] v;
      for (int i = 0; i < 2; i++) begin
         v = (i == 0) ? 10'h0 : 10'h1ff;
         ahb(1'b1, `ADDR_DESC_EXTENT, {2'h0, v[8:0], 21'h0});
         settle();
         check({22'h0, viewExtent}, {22'h0, v + 10'h1});
         ahb(1'b0, `ADDR_EXTENT, 32'h0);
         check(rd, {22'h0, v + 10'h1});
      end
   endtask
   // all ones: neighbouring bits must not leak into either offset
   task automatic testOffsets();
      ahb(1'b1, `ADDR_DESC_OFFSET, 32'hffff_ffff);
      settle();
      ahb(1'b0, `ADDR_XPIX, 32'h0);
      check(rd, 32'h0000_01fc);
      ahb(1'b0, `ADDR_YROW, 32'h0);
      check(rd, 32'h0000_001e);
   endtask
   // unaligned base, 8-byte pixels, then media access forcing 4-byte pixels
   task automatic testOrigin();
      ahb(1'b1, `ADDR_BASE, 32'h1234_5abc);
      ahb(1'b1, `ADDR_PITCH, 32'h0000_0100);
      ahb(1'b1, `ADDR_DESC_OFFSET, 32'h0620_0000);
      ahb(1'b1, `ADDR_CTRL, 32'h0000_0030);
      settle();
      check(originAddr, 32'h1234_5460);
      ahb(1'b1, `ADDR_CTRL, 32'h0000_0031);
      settle();
      check(originAddr, 32'h1234_5430);
      ahb(1'b0, `ADDR_ORIGIN, 32'h0);
      check(rd, 32'h1234_5430);
   endtask
   // read-only and unmapped places ignore writes
   task automatic testRefused();
      ahb(1'b1, `ADDR_ORIGIN, 32'hdead_beef);
      ahb(1'b1, 12'h040, 32'h5555_aaaa);
      settle();
      ahb(1'b0, `ADDR_ORIGIN, 32'h0);
      check(rd, 32'h1234_5430);
      ahb(1'b0, 12'h040, 32'h0);
      check(rd, 32'h0);
   endtask
   // media access with no row offset, then rows only with no pixel offset
   task automatic testMediaRows();
      ahb(1'b1, `ADDR_DESC_OFFSET, 32'h0a00_0000);
      settle();
      check(originAddr, 32'h1234_5050);
      ahb(1'b0, `ADDR_XPIX, 32'h0);
      check(rd, 32'h0000_0014);
      ahb(1'b1, `ADDR_DESC_OFFSET, 32'h0030_0000);
      settle();
      check(originAddr, 32'h1234_5600);
   endtask
   // ************
   // run
   // ************
   // a hang is cut short well past the 99 cycles the run needs
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_count++;
         wrap_up();
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      testReset();
      testExtent();
      testOffsets();
      testOrigin();
      testRefused();
      testMediaRows();
      wrap_up();
   end
endmodule
`default_nettype wire
